// file: src/uiqc_pkg.sv
package uiqc_pkg;

  // Register map, byte addresses on the AXI4-Lite bus
  localparam logic [3:0] UIQC_OFF_IDCTL  = 4'h0;
  localparam logic [3:0] UIQC_OFF_STATUS = 4'h4;
  localparam int         UIQC_ADDR_W     = 4;

  // Field positions inside the identity and queue control register
  localparam int UIQC_BIT_ENABLE = 0;
  localparam int UIQC_BIT_RXFL   = 1;
  localparam int UIQC_BIT_TXFL   = 2;
  localparam int UIQC_BIT_DMA    = 3;

  // Reset values of the write-side fields
  localparam logic UIQC_RST_DMA    = 1'h0;
  localparam logic UIQC_RST_ENABLE = 1'h1;

  // AXI responses
  localparam logic [1:0] UIQC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UIQC_RESP_SLVERR = 2'h2;

  // Interrupt source codes, lowest nibble of a read
  localparam logic [3:0] UIQC_ID_NONE    = 4'h1;
  localparam logic [3:0] UIQC_ID_TXEMPTY = 4'h2;
  localparam logic [3:0] UIQC_ID_RXDATA  = 4'h4;
  localparam logic [3:0] UIQC_ID_LINE    = 4'h6;
  localparam logic [3:0] UIQC_ID_BUSY    = 4'h7;
  localparam logic [3:0] UIQC_ID_TIMEOUT = 4'hC;

  // Pending sources, one bit each
  typedef struct packed {
    logic lineStatus;
    logic rxData;
    logic charTimeout;
    logic txEmpty;
    logic busyDetect;
  } uiqc_src_t;

  // Pulses and levels toward the queues and the DMA request logic
  typedef struct packed {
    logic txFlush;
    logic rxFlush;
    logic queueEnable;
    logic dmaScheme;
  } uiqc_ctl_t;

endpackage

// file: src/uiqc_id_encode.sv
`timescale 1ns/10ps
module uiqc_id_encode
  import uiqc_pkg::*;
(
  input  wire uiqc_src_t  pending,
  output logic [3:0]      irqSourceCode
);

  // Fixed priority: line status, data, timeout, tx empty, busy
  always_comb begin
    if (pending.lineStatus) begin
      irqSourceCode = UIQC_ID_LINE;
    end else if (pending.rxData) begin
      irqSourceCode = UIQC_ID_RXDATA;
    end else if (pending.charTimeout) begin
      irqSourceCode = UIQC_ID_TIMEOUT;
    end else if (pending.txEmpty) begin
      irqSourceCode = UIQC_ID_TXEMPTY;
    end else if (pending.busyDetect) begin
      irqSourceCode = UIQC_ID_BUSY;
    end else begin
      irqSourceCode = UIQC_ID_NONE;
    end
  end

endmodule

// file: src/uart_irq_id_fifo_control.sv
// Contract
// - A read of offset 0 returns the pending interrupt identifier in bits 3 to 0.
// - Identifier codes: none 1, tx empty 2, data 4, line 6, busy 7, timeout C.
// - Written bit 3 selects DMA request signalling scheme zero or one.
// - Writing 1 to bit 2 resets the transmit queue control to empty.
// - The transmit flush bit clears itself after taking effect.
// - Writing 1 to bit 1 resets receive queue control; it self-clears.
// - Bit 0 enables queues; any change of it flushes both queues.
`timescale 1ns/10ps
module uart_irq_id_fifo_control
  import uiqc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic [UIQC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [UIQC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire uiqc_src_t              pending,
  output uiqc_ctl_t                   queueCtl
);

  typedef struct packed {
    logic                   awHeld;
    logic [UIQC_ADDR_W-1:0] awAddr;
    logic                   wHeld;
    logic [7:0]             wData;
    logic                   wLane;
    logic                   bValid;
    logic [1:0]             bResp;
    logic                   rValid;
    logic [31:0]            rData;
    logic [1:0]             rResp;
    logic                   dmaScheme;
    logic                   queueEnable;
    logic                   txFlush;
    logic                   rxFlush;
  } uiqc_state_t;

  uiqc_state_t st_reg;
  uiqc_state_t st_next;
  logic [3:0]  irqSourceCode;
  logic        doWrite;
  logic        hitCtl;

  // Identifier is purely combinational so a read sees the current source
  uiqc_id_encode u_enc (
    .pending       (pending),
    .irqSourceCode (irqSourceCode)
  );

  // Address and data may arrive in either order; accept while not held and no response is pending
  assign s_axi_awready = !st_reg.awHeld && !st_reg.bValid;
  assign s_axi_wready  = !st_reg.wHeld && !st_reg.bValid;
  assign s_axi_arready = !st_reg.rValid;
  assign s_axi_bvalid  = st_reg.bValid;
  assign s_axi_bresp   = st_reg.bResp;
  assign s_axi_rvalid  = st_reg.rValid;
  assign s_axi_rdata   = st_reg.rData;
  assign s_axi_rresp   = st_reg.rResp;
  assign doWrite       = st_reg.awHeld && st_reg.wHeld && !st_reg.bValid;
  assign hitCtl        = st_reg.awAddr == UIQC_OFF_IDCTL;

  // Control outputs straight from flops; flush bits are one-cycle pulses
  assign queueCtl.txFlush     = st_reg.txFlush;
  assign queueCtl.rxFlush     = st_reg.rxFlush;
  assign queueCtl.queueEnable = st_reg.queueEnable;
  assign queueCtl.dmaScheme   = st_reg.dmaScheme;

  // Next state: bus handshakes and control field updates
  always_comb begin
    st_next         = st_reg;
    st_next.txFlush = 1'h0;
    st_next.rxFlush = 1'h0;
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.awHeld = 1'h1;
      st_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.wHeld = 1'h1;
      st_next.wData = s_axi_wdata[7:0];
      st_next.wLane = s_axi_wstrb[0];
    end
    if (doWrite) begin
      st_next.awHeld = 1'h0;
      st_next.wHeld  = 1'h0;
      st_next.bValid = 1'h1;
      st_next.bResp  = UIQC_RESP_OKAY;
      if (hitCtl && st_reg.wLane) begin
        st_next.dmaScheme   = st_reg.wData[UIQC_BIT_DMA];
        st_next.queueEnable = st_reg.wData[UIQC_BIT_ENABLE];
        // A change of the enable flushes both queues
        if (st_reg.wData[UIQC_BIT_ENABLE] != st_reg.queueEnable) begin
          st_next.txFlush = 1'h1;
          st_next.rxFlush = 1'h1;
        end
        if (st_reg.wData[UIQC_BIT_TXFL]) begin
          st_next.txFlush = 1'h1;
        end
        if (st_reg.wData[UIQC_BIT_RXFL]) begin
          st_next.rxFlush = 1'h1;
        end
      end else if (!hitCtl && st_reg.awAddr != UIQC_OFF_STATUS) begin
        st_next.bResp = UIQC_RESP_SLVERR;
      end
    end
    if (st_reg.bValid && s_axi_bready) begin
      st_next.bValid = 1'h0;
    end
    // A read of offset 0 returns the live identifier; offset 4 returns the written controls
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rValid = 1'h1;
      st_next.rResp  = UIQC_RESP_OKAY;
      st_next.rData  = 32'h0000_0000;
      if (s_axi_araddr == UIQC_OFF_IDCTL) begin
        st_next.rData[3:0] = irqSourceCode;
      end else if (s_axi_araddr == UIQC_OFF_STATUS) begin
        st_next.rData[UIQC_BIT_ENABLE] = st_reg.queueEnable;
        st_next.rData[UIQC_BIT_DMA]    = st_reg.dmaScheme;
      end else begin
        st_next.rResp = UIQC_RESP_SLVERR;
      end
    end else if (st_reg.rValid && s_axi_rready) begin
      st_next.rValid = 1'h0;
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg             <= '0;
      st_reg.dmaScheme   <= UIQC_RST_DMA;
      st_reg.queueEnable <= UIQC_RST_ENABLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Assertions: a read hands back the code seen at its address edge
  property p_read_id;
    @(posedge clk) disable iff (srst)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == UIQC_OFF_IDCTL)
      |=> (s_axi_rdata[3:0] == $past(irqSourceCode) && s_axi_rvalid);
  endproperty
  a_read_id: assert property (p_read_id)
    else $error("read id wrong");

  property p_none_code;
    @(posedge clk) disable iff (srst)
      (pending == '0) |-> (irqSourceCode == UIQC_ID_NONE);
  endproperty
  a_none_code: assert property (p_none_code)
    else $error("none code");

  property p_line_first;
    @(posedge clk) disable iff (srst)
      pending.lineStatus |-> (irqSourceCode == UIQC_ID_LINE);
  endproperty
  a_line_first: assert property (p_line_first)
    else $error("line prio");

  // Busy has the lowest priority, so it shows only when alone
  property p_busy_last;
    @(posedge clk) disable iff (srst)
      (pending == uiqc_src_t'(5'h01)) |-> (irqSourceCode == UIQC_ID_BUSY);
  endproperty
  a_busy_last: assert property (p_busy_last)
    else $error("busy code");

  // No stale code: the identifier follows the sources in the same cycle
  property p_id_follows;
    @(posedge clk) disable iff (srst)
      (pending.rxData && !pending.lineStatus)
      |-> (irqSourceCode == UIQC_ID_RXDATA);
  endproperty
  a_id_follows: assert property (p_id_follows)
    else $error("id not live");

  property p_dma_sel;
    @(posedge clk) disable iff (srst)
      (doWrite && hitCtl && st_reg.wLane)
      |=> queueCtl.dmaScheme == $past(st_reg.wData[UIQC_BIT_DMA]);
  endproperty
  a_dma_sel: assert property (p_dma_sel)
    else $error("dma scheme");

  // The scheme moves only on an accepted write to the control word
  property p_dma_hold;
    @(posedge clk) disable iff (srst)
      !(doWrite && hitCtl && st_reg.wLane) |=> $stable(queueCtl.dmaScheme);
  endproperty
  a_dma_hold: assert property (p_dma_hold)
    else $error("dma scheme moved");

  property p_tx_flush;
    @(posedge clk) disable iff (srst)
      (doWrite && hitCtl && st_reg.wLane && st_reg.wData[UIQC_BIT_TXFL])
      |=> queueCtl.txFlush;
  endproperty
  a_tx_flush: assert property (p_tx_flush)
    else $error("tx flush");

  // A flush pulse only ever rides along with the write response
  property p_flush_with_b;
    @(posedge clk) disable iff (srst)
      (queueCtl.txFlush || queueCtl.rxFlush) |-> s_axi_bvalid;
  endproperty
  a_flush_with_b: assert property (p_flush_with_b)
    else $error("flush without write");

  property p_tx_selfclr;
    @(posedge clk) disable iff (srst)
      queueCtl.txFlush |=> !queueCtl.txFlush;
  endproperty
  a_tx_selfclr: assert property (p_tx_selfclr)
    else $error("tx not clr");

  // Checked one edge after each reset edge, once the reset has landed
  property p_reset_val;
    @(posedge clk) srst |=> (queueCtl.dmaScheme == UIQC_RST_DMA
      && !queueCtl.txFlush && !queueCtl.rxFlush
      && queueCtl.queueEnable == UIQC_RST_ENABLE);
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("reset value");

  property p_rx_flush;
    @(posedge clk) disable iff (srst)
      (doWrite && hitCtl && st_reg.wLane && st_reg.wData[UIQC_BIT_RXFL])
      |=> queueCtl.rxFlush ##1 !queueCtl.rxFlush;
  endproperty
  a_rx_flush: assert property (p_rx_flush)
    else $error("rx flush");

  property p_rx_selfclr;
    @(posedge clk) disable iff (srst)
      queueCtl.rxFlush |=> !queueCtl.rxFlush;
  endproperty
  a_rx_selfclr: assert property (p_rx_selfclr)
    else $error("rx not clr");

  property p_enable_chg;
    @(posedge clk) disable iff (srst)
      $changed(queueCtl.queueEnable)
      |-> (queueCtl.txFlush && queueCtl.rxFlush);
  endproperty
  a_enable_chg: assert property (p_enable_chg)
    else $error("enable flush");

endmodule

// file: bench/uiqc_dma_model.sv
`timescale 1ns/10ps
// DMA side: counts flush pulses so their width and count are visible
module uiqc_dma_model
  import uiqc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      srst,
  input  wire uiqc_ctl_t queueCtl,
  output int             txFlushCnt,
  output int             rxFlushCnt
);
  // A pulse held two cycles counts twice, so a slow clear shows up
  always_ff @(posedge clk) begin
    if (srst) begin
      txFlushCnt <= 0;
      rxFlushCnt <= 0;
    end else begin
      txFlushCnt <= txFlushCnt + int'(queueCtl.txFlush);
      rxFlushCnt <= rxFlushCnt + int'(queueCtl.rxFlush);
    end
  end
endmodule

// file: bench/uart_irq_id_fifo_control_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin nFail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module uart_irq_id_fifo_control_tb_top
  import uiqc_pkg::*;
;
  logic        clk     = 1'h0;
  logic        srst    = 1'h1;
  logic        awV     = 1'h0;
  logic        wV      = 1'h0;
  logic        bR      = 1'h0;
  logic        arV     = 1'h0;
  logic        rR      = 1'h0;
  logic [3:0]  awA     = 4'h0;
  logic [3:0]  arA     = 4'h0;
  logic [3:0]  wS      = 4'hF;
  logic [31:0] wD      = 32'h0000_0000;
  logic [31:0] rD;
  logic        awRdy;
  logic        wRdy;
  logic        bV;
  logic        arRdy;
  logic        rV;
  logic [1:0]  bRs;
  logic [1:0]  rRs;
  uiqc_src_t   pending = '0;
  uiqc_ctl_t   queueCtl;
  int          nFail   = 0;
  int          nChecks = 0;
  int          cyc     = 0;
  int          txC;
  int          rxC;
  int          txE     = 0;
  int          rxE     = 0;
  logic [33:0] expQ[$];
  logic        en      = 1'h1;
  logic        ch;
  logic [7:0]  v;
  logic [31:0] r;
  logic [31:0] id;
  logic [7:0]  seq [5] = '{8'h09, 8'h05, 8'h03, 8'h00, 8'h01};

  uart_irq_id_fifo_control dut_u (.clk(clk), .srst(srst),
    .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy),
    .s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_wvalid(wV),
    .s_axi_wready(wRdy), .s_axi_bresp(bRs), .s_axi_bvalid(bV),
    .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV),
    .s_axi_arready(arRdy), .s_axi_rdata(rD), .s_axi_rresp(rRs),
    .s_axi_rvalid(rV), .s_axi_rready(rR), .pending(pending),
    .queueCtl(queueCtl));
  uiqc_dma_model dma_u (.clk(clk), .srst(srst), .queueCtl(queueCtl),
    .txFlushCnt(txC), .rxFlushCnt(rxC));

  initial begin
    forever #50 clk = ~clk;
  end

  // Priority as chosen: line, data, timeout, tx empty, busy
  function automatic logic [31:0] expId(uiqc_src_t p);
    if (p.lineStatus) return {28'h0, UIQC_ID_LINE};
    if (p.rxData) return {28'h0, UIQC_ID_RXDATA};
    if (p.charTimeout) return {28'h0, UIQC_ID_TIMEOUT};
    if (p.txEmpty) return {28'h0, UIQC_ID_TXEMPTY};
    if (p.busyDetect) return {28'h0, UIQC_ID_BUSY};
    return {28'h0, UIQC_ID_NONE};
  endfunction

  // Handshakes are sampled mid-cycle; a valid is dropped only after the
  // rising edge at which it was taken, never before its ready
  task automatic wr(logic [3:0] a, logic [7:0] d, logic [3:0] s,
                    logic [1:0] e);
    logic        ta;
    logic        tw;
    logic        tb;
    logic [31:0] u;
    expQ.push_back({e, 32'h0000_0000});
    u = $urandom;
    @(posedge clk);
    awA <= a;
    wD  <= {u[31:8], d};
    wS  <= s;
    awV <= 1'h1;
    wV  <= 1'h1;
    bR  <= 1'h1;
    do begin
      @(negedge clk);
      ta = awV && awRdy;
      tw = wV && wRdy;
      tb = bV && bR;
      @(posedge clk);
      if (ta) awV <= 1'h0;
      if (tw) wV <= 1'h0;
      if (tb) bR <= 1'h0;
    end while (!tb);
  endtask

  task automatic rd(logic [3:0] a, logic [1:0] s, logic [31:0] e);
    logic ta;
    logic tr;
    expQ.push_back({s, e});
    @(posedge clk);
    arA <= a;
    arV <= 1'h1;
    rR  <= 1'h1;
    do begin
      @(negedge clk);
      ta = arV && arRdy;
      tr = rV && rR;
      @(posedge clk);
      if (ta) arV <= 1'h0;
      if (tr) rR <= 1'h0;
    end while (!tr);
  endtask

  // Looked at a half cycle after the write ends, when the pulse is over
  // and the partner's counters have settled
  task automatic chkCtl(logic dma);
    @(negedge clk);
    `CHK(txC, txE)
    `CHK(rxC, rxE)
    `CHK(queueCtl, {2'h0, en, dma})
  endtask

  // Oldest note against each response as it is taken
  always @(negedge clk) begin
    if (bV && bR) `CHK({bRs, 32'h0}, expQ.pop_front())
    if (rV && rR) `CHK({rRs, rD}, expQ.pop_front())
  end

  task automatic stopTest();
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      nFail++;
      stopTest();
    end
  end

  initial begin
    void'($urandom(24));
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    rd(UIQC_OFF_STATUS, UIQC_RESP_OKAY, 32'h0000_0001);
    rd(UIQC_OFF_IDCTL, UIQC_RESP_OKAY, 32'h0000_0001);
    // Each source alone first, so every code is seen, then random mixes
    for (int i = 0; i < 45; i++) begin
      r = (i < 5) ? (32'h0000_0001 << i) : $urandom;
      id = expId(uiqc_src_t'(r[4:0]));
      @(posedge clk);
      pending <= uiqc_src_t'(r[4:0]);
      rd(UIQC_OFF_IDCTL, UIQC_RESP_OKAY, id);
    end
    rd(4'h8, UIQC_RESP_SLVERR, 32'h0000_0000);
    // Scheme, tx flush, rx flush, then enable off and on again
    foreach (seq[k]) begin
      v  = seq[k];
      ch = v[UIQC_BIT_ENABLE] != en;
      r  = $urandom;
      wr(UIQC_OFF_IDCTL, v, {r[3:1], 1'h1}, UIQC_RESP_OKAY);
      txE += int'(v[UIQC_BIT_TXFL] | ch);
      rxE += int'(v[UIQC_BIT_RXFL] | ch);
      en = v[UIQC_BIT_ENABLE];
      chkCtl(v[UIQC_BIT_DMA]);
      rd(UIQC_OFF_STATUS, UIQC_RESP_OKAY,
         {28'h000_0000, v[UIQC_BIT_DMA], 2'h0, en});
    end
    // Lane 0 off, a write to status, an unmapped write: none may act
    r = $urandom;
    wr(UIQC_OFF_IDCTL, 8'h0E, {r[3:1], 1'h0}, UIQC_RESP_OKAY);
    chkCtl(1'h0);
    wr(UIQC_OFF_STATUS, 8'h0F, 4'hF, UIQC_RESP_OKAY);
    chkCtl(1'h0);
    wr(4'h8, 8'h0F, 4'hF, UIQC_RESP_SLVERR);
    chkCtl(1'h0);
    rd(UIQC_OFF_STATUS, UIQC_RESP_OKAY, 32'h0000_0001);
    stopTest();
  end
endmodule
